//--- common/std_diag_pkg.sv
// Purpose: Constants and types for the standard diagnosis word
// Assumes: 16-bit diagnosis word, two LED channels
// Notes: Field positions, latch indices and reset values live here
package std_diag_pkg;

    // ==============================================================
    // Word layout
    localparam int WORD_W = 16;
    localparam int POS_MSB = 15;
    localparam int POS_SW_RESET = 14;
    localparam int POS_SUPPLY_UV = 13;
    localparam int POS_STATE_HI = 12;
    localparam int POS_STATE_LO = 11;
    localparam int POS_TER = 10;
    localparam int POS_MON = 9;
    localparam int POS_FAST = 8;
    localparam int POS_CAL = 7;
    localparam int POS_GATE2 = 6;
    localparam int POS_GATE1 = 5;
    localparam int POS_IVCC = 4;
    localparam int POS_FAULT2 = 3;
    localparam int POS_FAULT1 = 2;
    localparam int POS_TSD = 1;
    localparam int POS_TW = 0;
    localparam logic [15:0] WORD_CLEAN = 16'h1000;

    // ==============================================================
    // Read-cleared latches
    localparam int LAT_W = 5;
    localparam int LAT_SW = 0;
    localparam int LAT_UV = 1;
    localparam int LAT_GATE1 = 2;
    localparam int LAT_GATE2 = 3;
    localparam int LAT_IVCC = 4;
    localparam logic [4:0] LAT_RESET = 5'h02;
    localparam logic TER_RESET = 1'h1;
    localparam logic ANSWER_STD_RESET = 1'h1;

    // ==============================================================
    // Asynchronous condition inputs
    localparam int AIN_W = 10;
    localparam int AIN_SUPPLY_UV = 0;
    localparam int AIN_EN_UV = 1;
    localparam int AIN_GATE1 = 2;
    localparam int AIN_GATE2 = 3;
    localparam int AIN_IVCC = 4;
    localparam int AIN_EXTERNAL_GATE_DRIVER_SUPPLY = 5;
    localparam int AIN_TSD = 6;
    localparam int AIN_TW = 7;
    localparam int AIN_LIMP = 8;
    localparam int AIN_IDLE = 9;

    // ==============================================================
    // Completion mirrors
    localparam int MIR_W = 3;
    localparam int MIR_MON = 0;
    localparam int MIR_FAST = 1;
    localparam int MIR_CAL = 2;

    // ==============================================================
    // Frame length check
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] FRAME_MIN_BYTES = 2'h2;

    typedef enum logic [1:0] {
        OP_RESERVED = 2'b00,
        OP_LIMP = 2'b01,
        OP_ACTIVE = 2'b10,
        OP_IDLE = 2'b11
    } op_state_t;

endpackage : std_diag_pkg

//--- core/standard_diagnosis_word.sv
// Purpose: Builds the standard diagnosis word and its latches
// Assumes: Frame decoder and fault detectors run on clk
// Notes: Frame length is checked on sclk, result crosses as a level

module standard_diagnosis_word (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic supply_undervoltage,
    input wire logic enable_undervoltage_input,
    input wire logic ch1_gate_supply_low,
    input wire logic ch2_gate_supply_low,
    input wire logic internal_supply_low,
    input wire logic external_gate_driver_supply,
    input wire logic overtemperature,
    input wire logic temperature_warning,
    input wire logic limp_home,
    input wire logic idle_mode,
    input wire logic software_reset_event,
    input wire logic clear_latches_cmd,
    input wire logic std_request,
    input wire logic unused_register_access,
    input wire logic ch1_monitor_start,
    input wire logic ch2_monitor_start,
    input wire logic ch1_fast_switch_start,
    input wire logic ch2_fast_switch_start,
    input wire logic ch1_calibration_start,
    input wire logic ch2_calibration_start,
    input wire logic ch1_monitor_done,
    input wire logic ch2_monitor_done,
    input wire logic ch1_fast_switch_done,
    input wire logic ch2_fast_switch_done,
    input wire logic ch1_calibration_done,
    input wire logic ch2_calibration_done,
    input wire logic ch1_shorted_load,
    input wire logic ch1_open_load,
    input wire logic ch1_output_overvoltage,
    input wire logic ch2_shorted_load,
    input wire logic ch2_open_load,
    input wire logic ch2_output_overvoltage,
    output logic [15:0] standard_diagnosis,
    output logic answer_std_next,
    output logic latch_release,
    output logic thermal_halt
);

    // ==============================================================
    // Link side: bit counting on the serial clock
    logic fresh;
    logic [2:0] bit_in_byte;
    logic [1:0] byte_count;
    logic length_ok;

    // Set while no clock edge has yet been seen in the current frame
    always_ff @(posedge sclk or posedge reset or posedge chip_select_n) begin
        if (reset || chip_select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Count stays put after the frame so clk can read it at leisure
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            bit_in_byte <= 3'h0;
            byte_count <= 2'h0;
        end else if (fresh) begin
            bit_in_byte <= 3'h1;
            byte_count <= 2'h0;
        end else begin
            bit_in_byte <= bit_in_byte + 3'h1;
            if (bit_in_byte == std_diag_pkg::BIT_LAST &&
                byte_count != std_diag_pkg::FRAME_MIN_BYTES) begin
                byte_count <= byte_count + 2'h1;
            end
        end
    end

    assign length_ok = (bit_in_byte == 3'h0) &&
                       (byte_count == std_diag_pkg::FRAME_MIN_BYTES);

    // ==============================================================
    // Crossings into clk
    logic csn_meta;
    logic csn_sync;
    logic csn_prev;
    logic len_meta;
    logic frame_ok;
    logic [std_diag_pkg::AIN_W-1:0] async_in;
    logic [std_diag_pkg::AIN_W-1:0] pin_meta;
    logic [std_diag_pkg::AIN_W-1:0] pin_level;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            csn_meta <= 1'b1;
            csn_sync <= 1'b1;
            csn_prev <= 1'b1;
        end else begin
            csn_meta <= chip_select_n;
            csn_sync <= csn_meta;
            csn_prev <= csn_sync;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            len_meta <= 1'b0;
            frame_ok <= 1'b0;
        end else begin
            len_meta <= length_ok;
            frame_ok <= len_meta;
        end
    end

    assign async_in[std_diag_pkg::AIN_SUPPLY_UV] = supply_undervoltage;
    assign async_in[std_diag_pkg::AIN_EN_UV] = enable_undervoltage_input;
    assign async_in[std_diag_pkg::AIN_GATE1] = ch1_gate_supply_low;
    assign async_in[std_diag_pkg::AIN_GATE2] = ch2_gate_supply_low;
    assign async_in[std_diag_pkg::AIN_IVCC] = internal_supply_low;
    assign async_in[std_diag_pkg::AIN_EXTERNAL_GATE_DRIVER_SUPPLY] = external_gate_driver_supply;
    assign async_in[std_diag_pkg::AIN_TSD] = overtemperature;
    assign async_in[std_diag_pkg::AIN_TW] = temperature_warning;
    assign async_in[std_diag_pkg::AIN_LIMP] = limp_home;
    assign async_in[std_diag_pkg::AIN_IDLE] = idle_mode;

    genvar gi;
    generate
        for (gi = 0; gi < std_diag_pkg::AIN_W; gi++) begin : g_pin_sync
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pin_meta[gi] <= 1'b0;
                    pin_level[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= async_in[gi];
                    pin_level[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ==============================================================
    // Frame events
    logic frame_start;
    logic frame_end;
    logic std_clear;

    assign frame_start = !csn_sync && csn_prev;
    assign frame_end = csn_sync && !csn_prev;
    assign std_clear = frame_end && frame_ok && answer_std_next;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            answer_std_next <= std_diag_pkg::ANSWER_STD_RESET;
        end else if (frame_end) begin
            answer_std_next <= std_request || unused_register_access || !frame_ok;
        end
    end

    logic transfer_error_flag;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            transfer_error_flag <= std_diag_pkg::TER_RESET;
        end else if (frame_end) begin
            transfer_error_flag <= !frame_ok;
        end
    end

    // ==============================================================
    // Latched flags
    logic [std_diag_pkg::LAT_W-1:0] events;
    logic [std_diag_pkg::LAT_W-1:0] lat;
    logic [std_diag_pkg::LAT_W-1:0] shown;
    logic [std_diag_pkg::LAT_W-1:0] next_lat;
    logic thermal_shutdown_latched;
    logic next_tsd;

    assign events[std_diag_pkg::LAT_SW] = software_reset_event;
    assign events[std_diag_pkg::LAT_UV] = pin_level[std_diag_pkg::AIN_SUPPLY_UV] ||
                                          pin_level[std_diag_pkg::AIN_EN_UV];
    assign events[std_diag_pkg::LAT_GATE1] = pin_level[std_diag_pkg::AIN_GATE1];
    assign events[std_diag_pkg::LAT_GATE2] = pin_level[std_diag_pkg::AIN_GATE2];
    assign events[std_diag_pkg::LAT_IVCC] = pin_level[std_diag_pkg::AIN_IVCC] ||
                                            pin_level[std_diag_pkg::AIN_EXTERNAL_GATE_DRIVER_SUPPLY];

    // Snapshot of what the outgoing word carries
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shown <= '0;
        end else if (frame_start) begin
            shown <= lat;
        end
    end

    // New events always win over a clear
    always_comb begin
        next_lat = lat | events;
        if (clear_latches_cmd) begin
            next_lat = events;
        end else if (std_clear) begin
            next_lat = (lat & ~shown) | events;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lat <= std_diag_pkg::LAT_RESET;
        end else begin
            lat <= next_lat;
        end
    end

    assign next_tsd = pin_level[std_diag_pkg::AIN_TSD] || (thermal_shutdown_latched && !clear_latches_cmd);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            thermal_shutdown_latched <= 1'b0;
        end else begin
            thermal_shutdown_latched <= next_tsd;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_release <= 1'b0;
            thermal_halt <= 1'b0;
        end else begin
            latch_release <= clear_latches_cmd;
            thermal_halt <= next_tsd;
        end
    end

    // ==============================================================
    // Completion mirrors
    logic [std_diag_pkg::MIR_W-1:0] ch1_start;
    logic [std_diag_pkg::MIR_W-1:0] ch2_start;
    logic [std_diag_pkg::MIR_W-1:0] ch1_done;
    logic [std_diag_pkg::MIR_W-1:0] ch2_done;
    logic [std_diag_pkg::MIR_W-1:0] ch2_sel;
    logic [std_diag_pkg::MIR_W-1:0] mirror;

    assign ch1_start = {ch1_calibration_start, ch1_fast_switch_start, ch1_monitor_start};
    assign ch2_start = {ch2_calibration_start, ch2_fast_switch_start, ch2_monitor_start};
    assign ch1_done = {ch1_calibration_done, ch1_fast_switch_done, ch1_monitor_done};
    assign ch2_done = {ch2_calibration_done, ch2_fast_switch_done, ch2_monitor_done};

    generate
        for (gi = 0; gi < std_diag_pkg::MIR_W; gi++) begin : g_mirror
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    ch2_sel[gi] <= 1'b0;
                end else if (ch2_start[gi]) begin
                    ch2_sel[gi] <= 1'b1;
                end else if (ch1_start[gi]) begin
                    ch2_sel[gi] <= 1'b0;
                end
            end
            assign mirror[gi] = ch2_sel[gi] ? ch2_done[gi] : ch1_done[gi];
        end
    endgenerate

    // ==============================================================
    // Word assembly
    logic fault1;
    logic fault2;
    std_diag_pkg::op_state_t op_state;
    logic [15:0] next_word;

    assign fault1 = ch1_shorted_load || ch1_open_load || ch1_output_overvoltage;
    assign fault2 = ch2_shorted_load || ch2_open_load || ch2_output_overvoltage;

    always_comb begin
        if (pin_level[std_diag_pkg::AIN_LIMP]) begin
            op_state = std_diag_pkg::OP_LIMP;
        end else if (pin_level[std_diag_pkg::AIN_IDLE]) begin
            op_state = std_diag_pkg::OP_IDLE;
        end else begin
            op_state = std_diag_pkg::OP_ACTIVE;
        end
    end

    always_comb begin
        next_word = '0;
        next_word[std_diag_pkg::POS_SW_RESET] = lat[std_diag_pkg::LAT_SW];
        next_word[std_diag_pkg::POS_SUPPLY_UV] = lat[std_diag_pkg::LAT_UV];
        next_word[std_diag_pkg::POS_STATE_HI:std_diag_pkg::POS_STATE_LO] = op_state;
        next_word[std_diag_pkg::POS_TER] = transfer_error_flag;
        next_word[std_diag_pkg::POS_MON] = mirror[std_diag_pkg::MIR_MON];
        next_word[std_diag_pkg::POS_FAST] = mirror[std_diag_pkg::MIR_FAST];
        next_word[std_diag_pkg::POS_CAL] = mirror[std_diag_pkg::MIR_CAL];
        next_word[std_diag_pkg::POS_GATE2] = lat[std_diag_pkg::LAT_GATE2];
        next_word[std_diag_pkg::POS_GATE1] = lat[std_diag_pkg::LAT_GATE1];
        next_word[std_diag_pkg::POS_IVCC] = lat[std_diag_pkg::LAT_IVCC];
        next_word[std_diag_pkg::POS_FAULT2] = fault2;
        next_word[std_diag_pkg::POS_FAULT1] = fault1;
        next_word[std_diag_pkg::POS_TSD] = thermal_shutdown_latched;
        next_word[std_diag_pkg::POS_TW] = pin_level[std_diag_pkg::AIN_TW];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            standard_diagnosis <= '0;
        end else begin
            standard_diagnosis <= next_word;
        end
    end

    // ==============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_read_done;
        std_clear && !clear_latches_cmd;
    endsequence

    sequence s_gate1_gone;
        !lat[std_diag_pkg::LAT_GATE1] ##1 !standard_diagnosis[std_diag_pkg::POS_GATE1];
    endsequence

    property p_read_clears;
        s_read_done and shown[std_diag_pkg::LAT_GATE1] && !events[std_diag_pkg::LAT_GATE1]
            |=> s_gate1_gone;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("latch not cleared");

    property p_event_kept;
        s_read_done and events[std_diag_pkg::LAT_SW] |=> ##1
            standard_diagnosis[std_diag_pkg::POS_SW_RESET];
    endproperty
    a_event_kept: assert property (p_event_kept) else $error("event lost");

    property p_tsd_hold;
        thermal_shutdown_latched && !clear_latches_cmd |=> thermal_shutdown_latched ##1 standard_diagnosis[std_diag_pkg::POS_TSD];
    endproperty
    a_tsd_hold: assert property (p_tsd_hold) else $error("tsd dropped");

    property p_clear_cmd;
        clear_latches_cmd && !pin_level[std_diag_pkg::AIN_TSD]
            |=> !thermal_shutdown_latched && latch_release && !thermal_halt;
    endproperty
    a_clear_cmd: assert property (p_clear_cmd) else $error("clear failed");

    // Word still holds its reset value at the first edge after release
    property p_msb_state;
        !standard_diagnosis[std_diag_pkg::POS_MSB] && ($past(reset) ||
            standard_diagnosis[std_diag_pkg::POS_STATE_HI:std_diag_pkg::POS_STATE_LO] != 2'b00);
    endproperty
    a_msb_state: assert property (p_msb_state) else $error("msb or state bad");

    property p_sw_seen;
        software_reset_event |-> ##2 standard_diagnosis[std_diag_pkg::POS_SW_RESET];
    endproperty
    a_sw_seen: assert property (p_sw_seen) else $error("sw reset not shown");

    property p_ter;
        frame_end |=> (transfer_error_flag == !$past(frame_ok)) ##1
            (standard_diagnosis[std_diag_pkg::POS_TER] == $past(transfer_error_flag));
    endproperty
    a_ter: assert property (p_ter) else $error("ter wrong");

    property p_fault_or;
        ##1 standard_diagnosis[std_diag_pkg::POS_FAULT1] == $past(fault1) &&
            standard_diagnosis[std_diag_pkg::POS_FAULT2] == $past(fault2);
    endproperty
    a_fault_or: assert property (p_fault_or) else $error("fault mirror wrong");

    property p_mirror;
        ch2_monitor_start |=> ##1
            standard_diagnosis[std_diag_pkg::POS_MON] == $past(ch2_monitor_done);
    endproperty
    a_mirror: assert property (p_mirror) else $error("monitor mirror wrong");

    property p_unused_std;
        frame_end && unused_register_access |=> answer_std_next;
    endproperty
    a_unused_std: assert property (p_unused_std) else $error("no std answer");

    property p_clean;
        lat == '0 && !transfer_error_flag && !thermal_shutdown_latched && mirror == '0 && !fault1 && !fault2 &&
            !pin_level[std_diag_pkg::AIN_TW] && !pin_level[std_diag_pkg::AIN_LIMP] &&
            !pin_level[std_diag_pkg::AIN_IDLE] |=> standard_diagnosis == std_diag_pkg::WORD_CLEAN;
    endproperty
    a_clean: assert property (p_clean) else $error("clean word wrong");

    property p_warning;
        ##1 standard_diagnosis[std_diag_pkg::POS_TW] == $past(pin_level[std_diag_pkg::AIN_TW]);
    endproperty
    a_warning: assert property (p_warning) else $error("warning not live");

endmodule : standard_diagnosis_word

//--- test/spi_host_model.sv
// Purpose: Host side of the serial link, framing chip select and serial clock
// Assumes: Serial clock period 48 ns, lead 200 ns, lag 200 ns, gap 250 ns
// Notes: Serial clock stands still low outside frames
module spi_host_model (
    output logic sclk,
    output logic chip_select_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
    end

    // ==============================================================
    // Frame of n serial clock pulses
    task automatic frame(input int n);
        #3.3;
        chip_select_n = 1'b0;
        #200;
        repeat (n) begin
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
            #24;
        end
        #200;
        chip_select_n = 1'b1;
        #250;
    endtask : frame
endmodule : spi_host_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the standard diagnosis word
// Assumes: Clock 200 MHz, host model frames the link
// Notes: Expected word is rebuilt from a bench-side copy of every latch
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, reset, sclk, chip_select_n, sw_event, clr, std_req, unused;
    logic [9:0] lv;
    logic [5:0] st, dn, fl;
    logic [15:0] word;
    logic answer_next, release_pulse, halt;
    logic m_sw, m_uv, m_g1, m_g2, m_iv, m_ter, m_tsd, m_ans, sel_mon, sel_fast, sel_cal;
    int err_total = 0;
    int check_count = 0;

    standard_diagnosis_word standard_diagnosis_word_inst (
        .clk(clk), .reset(reset), .sclk(sclk), .chip_select_n(chip_select_n),
        .supply_undervoltage(lv[0]), .enable_undervoltage_input(lv[1]),
        .ch1_gate_supply_low(lv[2]), .ch2_gate_supply_low(lv[3]),
        .internal_supply_low(lv[4]), .external_gate_driver_supply(lv[5]),
        .overtemperature(lv[6]), .temperature_warning(lv[7]),
        .limp_home(lv[8]), .idle_mode(lv[9]),
        .software_reset_event(sw_event), .clear_latches_cmd(clr),
        .std_request(std_req), .unused_register_access(unused),
        .ch1_monitor_start(st[0]), .ch2_monitor_start(st[1]),
        .ch1_fast_switch_start(st[2]), .ch2_fast_switch_start(st[3]),
        .ch1_calibration_start(st[4]), .ch2_calibration_start(st[5]),
        .ch1_monitor_done(dn[0]), .ch2_monitor_done(dn[1]),
        .ch1_fast_switch_done(dn[2]), .ch2_fast_switch_done(dn[3]),
        .ch1_calibration_done(dn[4]), .ch2_calibration_done(dn[5]),
        .ch1_shorted_load(fl[0]), .ch1_open_load(fl[1]), .ch1_output_overvoltage(fl[2]),
        .ch2_shorted_load(fl[3]), .ch2_open_load(fl[4]), .ch2_output_overvoltage(fl[5]),
        .standard_diagnosis(word), .answer_std_next(answer_next),
        .latch_release(release_pulse), .thermal_halt(halt)
    );

    spi_host_model spi_host_model_inst (.sclk(sclk), .chip_select_n(chip_select_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==============================================================
    // Expectations and comparisons
    function automatic logic [15:0] exp_word();
        logic [15:0] w;
        w = 16'h0000;
        w[14] = m_sw;
        w[13] = m_uv;
        w[12:11] = lv[8] ? 2'b01 : (lv[9] ? 2'b11 : 2'b10);
        w[10] = m_ter;
        w[9] = dn[0 + sel_mon];
        w[8] = dn[2 + sel_fast];
        w[7] = dn[4 + sel_cal];
        w[6] = m_g2;
        w[5] = m_g1;
        w[4] = m_iv;
        w[3] = |fl[5:3];
        w[2] = |fl[2:0];
        w[1] = m_tsd;
        w[0] = lv[7];
        return w;
    endfunction : exp_word

    task automatic cmp16(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask : cmp16

    task automatic cmp1(input string name, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", name, e, g);
        end
    endtask : cmp1

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic settle_check();
        repeat (6) @(posedge clk);
        #1;
        cmp16("word", exp_word(), word);
        cmp1("thermal_halt", m_tsd, halt);
    endtask : settle_check

    // ==============================================================
    // Link frames and their side effects
    task automatic do_frame(input int n, input logic req, input logic unu);
        logic ok;
        @(posedge clk);
        std_req <= req;
        unused <= unu;
        spi_host_model_inst.frame(n);
        ok = (n >= 16) && (n % 8 == 0);
        if (ok && m_ans) begin
            {m_sw, m_uv, m_g1, m_g2, m_iv} = {sw_event, lv[0] | lv[1], lv[2], lv[3], lv[4] | lv[5]};
        end
        m_ter = !ok;
        m_ans = ok ? (req | unu) : 1'b1;
        cmp1("answer_std_next", m_ans, answer_next);
        settle_check();
    endtask : do_frame

    task automatic pulse_sw();
        @(posedge clk);
        sw_event <= 1'b1;
        @(posedge clk);
        sw_event <= 1'b0;
        m_sw = 1'b1;
    endtask : pulse_sw

    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        logic [9:0] nlv;
        logic [5:0] nst;
        int s;
        {sw_event, clr, std_req, unused, lv, st, dn, fl} = '0;
        {m_sw, m_g1, m_g2, m_iv, m_tsd, sel_mon, sel_fast, sel_cal} = '0;
        {m_uv, m_ter, m_ans} = 3'h7;
        reset = 1'b1;
        void'($urandom(65190));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        cmp16("word in reset", 16'h0000, word);
        settle_check();
        cmp16("word after reset", 16'h3400, word);
        do_frame(16, 1'b1, 1'b0);
        cmp16("clean word", 16'h1000, word);
        pulse_sw();
        do_frame(15, 1'b1, 1'b0);
        cmp1("bit 14 kept", 1'b1, word[14]);
        do_frame(24, 1'b0, 1'b0);
        pulse_sw();
        do_frame(16, 1'b0, 1'b1);
        do_frame(32, 1'b1, 1'b0);
        // Event still present as the read frame ends must survive the clear
        @(posedge clk);
        sw_event <= 1'b1;
        do_frame(16, 1'b1, 1'b0);
        @(posedge clk);
        sw_event <= 1'b0;
        for (int i = 0; i < 150; i++) begin
            s = $urandom % 3;
            nlv = {s == 2, s == 1, 1'($urandom % 2), 7'($urandom & $urandom & $urandom)};
            nst = 6'($urandom);
            @(posedge clk);
            lv <= nlv;
            st <= nst;
            dn <= 6'($urandom);
            fl <= 6'($urandom & $urandom);
            sel_mon = nst[1] ? 1'b1 : (nst[0] ? 1'b0 : sel_mon);
            sel_fast = nst[3] ? 1'b1 : (nst[2] ? 1'b0 : sel_fast);
            sel_cal = nst[5] ? 1'b1 : (nst[4] ? 1'b0 : sel_cal);
            m_uv |= nlv[0] | nlv[1];
            m_g1 |= nlv[2];
            m_g2 |= nlv[3];
            m_iv |= nlv[4] | nlv[5];
            m_tsd |= nlv[6];
            @(posedge clk);
            st <= 6'h00;
            settle_check();
        end
        @(posedge clk);
        lv <= 10'h040;
        m_tsd = 1'b1;
        repeat (4) @(posedge clk);
        lv <= 10'h000;
        do_frame(16, 1'b1, 1'b0);
        pulse_sw();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        cmp1("latch_release", 1'b1, release_pulse);
        cmp1("thermal_halt cleared", 1'b0, halt);
        @(posedge clk);
        #1;
        cmp1("latch_release end", 1'b0, release_pulse);
        {m_sw, m_uv, m_g1, m_g2, m_iv, m_tsd} = 6'h00;
        settle_check();
        tally_and_finish();
    end
endmodule : testbench
